/* logic/ipc_codec.sv */
// infrared pulse encoder and decoder with an axi4-lite control slave
//
// Behaviour
// [R1] enabled in async mode: rx pin feeds decoder, tx pin driven by encoder
// [R2] synchronous mode keeps the codec off whatever the enable bit says
// [R3] all pulse timing counts sixteen-times baud clock ticks
// [R4] a one bit is sent as zero for all sixteen ticks
// [R5] a zero bit is sent as 7 ticks low, 3 high, 6 low
// [R6] transmit polarity bit touches only the encoder output
// [R7] transmit polarity clear idles low, set inverts so line idles high
// [R8] each falling rx edge holds decoded data low for sixteen ticks
// [R9] at expiry stay low sixteen more if an edge came, else go high
// [R10] decoded stream lags source by seven to eight ticks
// [R11] receive polarity bit touches only the decoder path
// [R12] receive polarity clear means rx idles high, set means idles low
// [R13] one-tick high glitch from a missed edge is left to majority vote
// [R14] codec only usable in sixteen-times mode, never in four-times mode
// [R15] set receive polarity inverts rx pin before edge detection
`timescale 1ns/1ps

module ipc_codec #(
   parameter int ADDR_W = ipc_pkg::ADDR_W
) (
   input  wire logic                       CORE_CLK,
   input  wire logic                       RST_N,
   input  wire logic [ADDR_W-1:0]          S_AXI_AWADDR,
   input  wire logic                       S_AXI_AWVALID,
   output      logic                       S_AXI_AWREADY,
   input  wire logic [ipc_pkg::DATA_W-1:0] S_AXI_WDATA,
   input  wire logic [3:0]                 S_AXI_WSTRB,
   input  wire logic                       S_AXI_WVALID,
   output      logic                       S_AXI_WREADY,
   output      logic [1:0]                 S_AXI_BRESP,
   output      logic                       S_AXI_BVALID,
   input  wire logic                       S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0]          S_AXI_ARADDR,
   input  wire logic                       S_AXI_ARVALID,
   output      logic                       S_AXI_ARREADY,
   output      logic [ipc_pkg::DATA_W-1:0] S_AXI_RDATA,
   output      logic [1:0]                 S_AXI_RRESP,
   output      logic                       S_AXI_RVALID,
   input  wire logic                       S_AXI_RREADY,
   input  wire logic                       BAUD_TICK16,
   input  wire logic                       SYNC_MODE,
   input  wire logic                       BAUD_4X_MODE,
   input  wire logic                       TX_BIT_STRB,
   input  wire logic                       TX_SERIAL_IN,
   output      logic                       RX_DECODED_OUT,
   output      logic                       CODEC_ACTIVE,
   input  wire logic                       SERIAL_RECEIVE_PIN,
   output      logic                       SERIAL_TRANSMIT_PIN
);
   import ipc_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // offsets are package constants, so the address cannot grow past them
   if (ADDR_W < 3 || ADDR_W > ipc_pkg::ADDR_W)
   begin : g_chk
      $error("ipc_codec: ADDR_W must fit the register offsets");
   end

   ipc_ctrl_t           ctrl;
   logic                aw_held;
   logic                w_held;
   logic [ADDR_W-1:0]   aw_addr;
   logic [DATA_W-1:0]   w_data;
   logic [3:0]          w_strb;
   logic                active;
   logic                rx_s1;
   logic                rx_s2;
   logic                rx_s3;
   logic                rx_lvl;
   logic                rx_prev;
   logic                rx_norm;
   logic                fall;
   logic                pend;
   logic                pend_eff;
   ipc_dec_t            dec_state;
   logic [3:0]          dec_cnt;
   logic [3:0]          phase;
   logic                tx_bit;
   logic                enc;

   // ------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------
   // address and data are held separately so either may come first
   assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;

   // capture of the write address and data
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= 4'h0;
      end
      else if (aw_held && w_held)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
      end
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= RESP_OKAY;
      end
      else if (aw_held && w_held)
      begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= (aw_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
                         ? RESP_OKAY : RESP_SLV;
      end
      else if (S_AXI_BREADY)
      begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // control register; only byte lane zero carries fields
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         ctrl <= CTRL_RST;
      end
      else if (aw_held && w_held && w_strb[0] &&
               aw_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
      begin
         ctrl.enable <= w_data[CTRL_EN_BIT];
         ctrl.tx_pol <= w_data[CTRL_TXPOL_BIT];
         ctrl.rx_pol <= w_data[CTRL_RXPOL_BIT];
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   // read data answers the cycle after the address is taken
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= '0;
         S_AXI_RRESP  <= RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA  <= '0;
         S_AXI_RRESP  <= RESP_OKAY;
         if (S_AXI_ARADDR[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
         begin
            S_AXI_RDATA[CTRL_EN_BIT]    <= ctrl.enable;
            S_AXI_RDATA[CTRL_TXPOL_BIT] <= ctrl.tx_pol;
            S_AXI_RDATA[CTRL_RXPOL_BIT] <= ctrl.rx_pol;
         end
         else if (S_AXI_ARADDR[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2])
         begin
            S_AXI_RDATA[STAT_ACT_BIT] <= active;
            S_AXI_RDATA[STAT_RXD_BIT] <= RX_DECODED_OUT;
            S_AXI_RDATA[STAT_TXP_BIT] <= SERIAL_TRANSMIT_PIN;
         end
         else
         begin
            S_AXI_RRESP <= RESP_SLV;
         end
      end
      else if (S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // mode gating
   // ------------------------------------------------------------
   // the pulse shapes need sixteen ticks per bit, so four-times mode
   // and any synchronous mode leave the plain serial path in place
   assign active       = ctrl.enable && !SYNC_MODE && !BAUD_4X_MODE; // [R1] [R2] [R14]
   assign CODEC_ACTIVE = active;

   // ------------------------------------------------------------
   // receive pin conditioning
   // ------------------------------------------------------------
   // three stages; the level moves only when stages two and three agree
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         rx_s1  <= 1'b1;
         rx_s2  <= 1'b1;
         rx_s3  <= 1'b1;
         rx_lvl <= 1'b1;
      end
      else
      begin
         rx_s1 <= SERIAL_RECEIVE_PIN;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3)
         begin
            rx_lvl <= rx_s3;
         end
      end
   end

   // an idle-low line is inverted so one detector serves both levels;
   // toggling the polarity bit mid-frame can fake one edge
   assign rx_norm = rx_lvl ^ ctrl.rx_pol; // [R11] [R12] [R15]
   assign fall    = rx_prev && !rx_norm;  // [R8]

   // previous level for the edge detector
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         rx_prev <= 1'b1;
      end
      else
      begin
         rx_prev <= rx_norm;
      end
   end

   // ------------------------------------------------------------
   // decoder
   // ------------------------------------------------------------
   // an edge between ticks is remembered; a new edge beats the clear
   assign pend_eff = pend || fall;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         pend <= 1'b0;
      end
      else if (fall)
      begin
         pend <= !(BAUD_TICK16 && (dec_state == DEC_HIGH ||
                   dec_cnt == BIT_LAST)); // [R8]
      end
      else if (BAUD_TICK16 && (dec_state == DEC_HIGH ||
               dec_cnt == BIT_LAST))
      begin
         pend <= 1'b0;
      end
   end

   // low stretcher; a missed edge gives a one-tick high blip that the
   // receiver's majority vote absorbs, so it is not filtered here [R13]
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         dec_state <= DEC_HIGH;
         dec_cnt   <= 4'h0;
      end
      else if (BAUD_TICK16) // [R3]
      begin
         case (dec_state)
            DEC_HIGH:
            begin
               if (pend_eff)
               begin
                  dec_state <= DEC_LOW; // [R8]
                  dec_cnt   <= 4'h0;
               end
            end
            DEC_LOW:
            begin
               if (dec_cnt != BIT_LAST)
               begin
                  dec_cnt <= dec_cnt + 4'h1;
               end
               else if (pend_eff)
               begin
                  dec_cnt <= 4'h0; // [R9]
               end
               else
               begin
                  dec_state <= DEC_HIGH; // [R9]
               end
            end
            default:
            begin
               dec_state <= DEC_HIGH;
            end
         endcase
      end
   end

   // decoded output; the pulse sits seven ticks into the source bit, so
   // the stream trails the source by seven to eight ticks [R10]
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         RX_DECODED_OUT <= 1'b1;
      end
      else
      begin
         RX_DECODED_OUT <= active ? (dec_state == DEC_HIGH) : rx_lvl; // [R1]
      end
   end

   // ------------------------------------------------------------
   // encoder
   // ------------------------------------------------------------
   // bit phase restarts on the shifter's bit strobe and runs on ticks
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         phase  <= 4'h0;
         tx_bit <= 1'b1;
      end
      else if (TX_BIT_STRB)
      begin
         phase  <= 4'h0;
         tx_bit <= TX_SERIAL_IN;
      end
      else if (BAUD_TICK16) // [R3]
      begin
         phase <= phase + 4'h1;
      end
   end

   // ones stay dark; zeros light for three ticks after seven
   assign enc = !tx_bit && phase >= PULSE_FIRST &&
                phase <= PULSE_LAST; // [R4] [R5]

   // transmit pin; polarity acts on the encoded path alone
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         SERIAL_TRANSMIT_PIN <= 1'b1;
      end
      else
      begin
         SERIAL_TRANSMIT_PIN <= active ? (enc ^ ctrl.tx_pol) // [R6] [R7]
                                       : TX_SERIAL_IN;       // [R1]
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_sync_blocks: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (SYNC_MODE || BAUD_4X_MODE) |-> !CODEC_ACTIVE) // [R2]
      else $error("codec active outside async sixteen-times mode");

   a_one_dark: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (active && tx_bit && !ctrl.tx_pol) |=> !SERIAL_TRANSMIT_PIN) // [R4]
      else $error("one bit produced light");

   a_zero_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (active && !tx_bit && !ctrl.tx_pol && !TX_BIT_STRB &&
       phase == 4'h6 && BAUD_TICK16) |=> ##1 SERIAL_TRANSMIT_PIN) // [R5]
      else $error("zero bit pulse missing at tick seven");

   a_zero_edge: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (active && !tx_bit && !ctrl.tx_pol && phase == 4'ha)
      |=> !SERIAL_TRANSMIT_PIN) // [R5]
      else $error("zero bit pulse too long");

   a_idle_invert: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (active && tx_bit && ctrl.tx_pol) |=> SERIAL_TRANSMIT_PIN) // [R7]
      else $error("inverted idle not high");

   a_low_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (dec_state == DEC_HIGH && BAUD_TICK16 && pend_eff)
      |=> dec_state == DEC_LOW && dec_cnt == 4'h0) // [R8]
      else $error("edge did not start a low interval");

   a_edge_kept: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (fall && !BAUD_TICK16) |=> pend) // [R8]
      else $error("falling edge lost");

   a_low_extend: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (dec_state == DEC_LOW && dec_cnt == BIT_LAST && BAUD_TICK16 &&
       pend_eff) |=> dec_state == DEC_LOW && dec_cnt == 4'h0) // [R9]
      else $error("low interval not extended");

   a_low_end: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (active && dec_state == DEC_LOW && dec_cnt == BIT_LAST &&
       BAUD_TICK16 && !pend_eff) |=> ##1 RX_DECODED_OUT) // [R9]
      else $error("decoded data did not return high");

   a_rx_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !active |=> RX_DECODED_OUT == $past(rx_lvl)) // [R1]
      else $error("plain receive path broken");

   a_tx_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !active |=> SERIAL_TRANSMIT_PIN == $past(TX_SERIAL_IN)) // [R6]
      else $error("plain transmit path broken");

endmodule : ipc_codec

/* logic/ipc_pkg.sv */
// shared constants and types for the infrared pulse codec
package ipc_pkg;

   // ------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_TXPOL_BIT = 1;
   localparam int CTRL_RXPOL_BIT = 2;
   localparam int STAT_ACT_BIT   = 0;
   localparam int STAT_RXD_BIT   = 1;
   localparam int STAT_TXP_BIT   = 2;

   // ------------------------------------------------------------
   // reset values and bus answers
   // ------------------------------------------------------------
   localparam logic [2:0] CTRL_RST  = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLV  = 2'h2;

   // ------------------------------------------------------------
   // pulse timing, in ticks of the sixteen-times baud clock
   // ------------------------------------------------------------
   localparam logic [3:0] BIT_LAST    = 4'hf;
   localparam logic [3:0] PULSE_FIRST = 4'h7;
   localparam logic [3:0] PULSE_LAST  = 4'h9;

   // control fields as one carrier
   typedef struct packed {
      logic rx_pol;
      logic tx_pol;
      logic enable;
   } ipc_ctrl_t;

   typedef enum logic [0:0] {
      DEC_HIGH,
      DEC_LOW
   } ipc_dec_t;

endpackage : ipc_pkg

/* tb/ipc_ir_xcvr.sv */
// infrared transceiver model driving the codec's receive pin
`timescale 1ns/1ps

module ipc_ir_xcvr (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic tick,
   input  wire logic bit_strb,
   input  wire logic bit_val,
   input  wire logic idle_low,
   output      logic rx_pin
);
   logic [3:0] phase;
   logic       zero;

   // ------------------------------------------------------------
   // bit framing on the same sixteen-times tick as the codec
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         phase <= 4'h0;
         zero  <= 1'h0;
      end
      else if (tick && bit_strb)
      begin
         phase <= 4'h0;
         zero  <= !bit_val;
      end
      else if (tick)
      begin
         phase <= phase + 4'h1;
      end
   end

   // a zero bit flashes in ticks 7 to 9; the flash is the non-idle level
   assign rx_pin = (zero && phase >= 4'h7 && phase <= 4'h9) ^ !idle_low;

endmodule : ipc_ir_xcvr

/* tb/tb.sv */
// self-checking bench for the infrared pulse codec
`timescale 1ns/1ps

module tb;
   import ipc_pkg::*;

   logic              clk, rst_n, tick, sync_mode, mode_4x, strb, tx_in;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic              rx_out, active, rx_pin, tx_pin, rx_bit, b, prev, act;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, rd;
   logic [1:0]        bresp, rresp, rr, wr, idle_exp;
   logic [4:0]        cfg;
   logic [4:0]        corner [4] = '{5'h01, 5'h07, 5'h0b, 5'h15};
   ipc_ctrl_t         ctrl;
   integer            seed;
   int                failures, tests_run;

   ipc_codec DUT (
      .CORE_CLK(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .BAUD_TICK16(tick), .SYNC_MODE(sync_mode), .BAUD_4X_MODE(mode_4x),
      .TX_BIT_STRB(strb), .TX_SERIAL_IN(tx_in), .RX_DECODED_OUT(rx_out),
      .CODEC_ACTIVE(active), .SERIAL_RECEIVE_PIN(rx_pin),
      .SERIAL_TRANSMIT_PIN(tx_pin)
   );

   ipc_ir_xcvr partner (
      .clk(clk), .rst_n(rst_n), .tick(tick), .bit_strb(strb),
      .bit_val(rx_bit), .idle_low(ctrl.rx_pol), .rx_pin(rx_pin)
   );

   // ------------------------------------------------------------
   // clock and helpers
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // pin during tick k of a bit; the plain path passes the bit through
   function automatic logic tx_exp(input logic v, input int k);
      if (!act)
         return v;
      return (!v && k >= 7 && k <= 9) ^ ctrl.tx_pol;
   endfunction : tx_exp

   task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
      logic done;
      done = 1'h0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!done)
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            wr = bresp;
            bready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a);
      logic done;
      done = 1'h0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!done)
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            rd = rdata;
            rr = rresp;
            rready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask : axi_read

   // one bit slot: 16 ticks, 8 cycles apart, transmit pin checked every tick;
   // the spacing lets the pin synchroniser settle within one tick
   task automatic run_bit(input logic chk_rx);
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clk);
         tick   <= 1'h1;
         strb   <= (k == 0);
         tx_in  <= b;
         rx_bit <= b;
         @(posedge clk);
         tick <= 1'h0;
         strb <= 1'h0;
         @(posedge clk);
         @(negedge clk);
         check(tx_pin, tx_exp(b, k));
         // decoded level lags by 7..8 ticks: tick 6 still shows prev and
         // from tick 8 on this bit; the plain path sees the flash 8..10
         if (chk_rx && act && (k == 6 || k >= 8))
            check(rx_out, (k == 6) ? prev : b);
         if (chk_rx && !act && (k == 6 || k > 10))
            check(rx_out, !ctrl.rx_pol);
         repeat (5) @(posedge clk);
      end
   endtask : run_bit

   task automatic test_done;
      $display("checks %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      seed = 32'h70f6_dda5;
      failures = 0;
      tests_run = 0;
      {rst_n, tick, sync_mode, mode_4x, strb, rx_bit} = 6'h00;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, tx_in, ctrl} = '0;
      tx_in = 1'h1;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(negedge clk);
      check({tx_pin, rx_out, active}, 3'h6);
      axi_read(CTRL_OFS);
      check(rd, {29'h0, CTRL_RST});
      axi_read(4'h8);
      check(rd, 32'h0);
      check(rr, RESP_SLV);
      axi_write(STAT_OFS, 32'h7);
      check(wr, RESP_SLV);
      $display("test registers done");
      // corners first, then random modes; plain path included
      for (int i = 0; i < 12; i++)
      begin
         cfg = (i < 4) ? corner[i] : 5'($random(seed));
         sync_mode <= cfg[3];
         mode_4x <= cfg[4];
         ctrl <= cfg[2:0]; // partner idle level moves off the sampling edge
         act = cfg[0] && !cfg[3] && !cfg[4];
         axi_write(CTRL_OFS, {29'h0, cfg[2:0]});
         check(wr, RESP_OKAY);
         axi_read(CTRL_OFS);
         check(rd, {29'h0, cfg[2:0]});
         axi_read(STAT_OFS);
         check(rd[STAT_ACT_BIT], act);
         check(active, act);
         // idle status: encoder dark or plain line high, decoder high or plain rx at its idle level
         idle_exp = {act ? ctrl.tx_pol : 1'h1, act || !ctrl.rx_pol};
         check(rd[STAT_TXP_BIT:STAT_RXD_BIT], idle_exp);
         prev = 1'h1;
         // slot 0 is a one so a fake edge from a polarity change dies out,
         // slots 1 and 2 are zeros back to back to retrigger the low, and
         // the last slot is a one that leaves the decoder high
         for (int n = 0; n < 7; n++)
         begin
            b = (n == 1 || n == 2) ? 1'h0 :
                (n == 0 || n == 6) ? 1'h1 : 1'($random(seed));
            run_bit(n > 0);
            prev = b;
         end
         $display("test config %0d done", i);
      end
      test_done;
   end

   // cuts a hang short; the full run takes about 11,000 cycles
   initial
   begin
      repeat (50000) @(posedge clk);
      failures++;
      test_done;
   end

endmodule : tb
